// ### bench/tb_usb_descriptor_defaults.sv
`timescale 1ns/1ps

module tb_usb_descriptor_defaults
   import usb_descriptor_defaults_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic high_speed = 1'b0;
   logic eeprom_valid = 1'b0;
   logic power_source_strap = 1'b0;
   logic remote_wakeup_strap = 1'b0;
   logic load_valid = 1'b0;
   logic [FIELD_ADDR_W-1:0] load_addr = 6'h00;
   logic [7:0] load_data = 8'h00;
   logic req_valid;
   logic [1:0] req_desc;
   logic [15:0] req_length;
   logic req_ready;
   logic byte_valid;
   logic [7:0] byte_data;
   logic byte_last;
   logic byte_ready;
   logic [7:0] mem [64];
   int seed = 32'h48c9;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;

   // Config header at store indices 1 to 6: length, type, total, interfaces, value
   localparam logic [47:0] CFG_HDR = 48'h090727000101;

   always #4 clk = ~clk;

   usb_descriptor_defaults i_usb_descriptor_defaults (
      .clk(clk),
      .rst_n(rst_n),
      .high_speed(high_speed),
      .eeprom_valid(eeprom_valid),
      .power_source_strap(power_source_strap),
      .remote_wakeup_strap(remote_wakeup_strap),
      .load_valid(load_valid),
      .load_addr(load_addr),
      .load_data(load_data),
      .req_valid(req_valid),
      .req_desc(req_desc),
      .req_length(req_length),
      .req_ready(req_ready),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .byte_last(byte_last),
      .byte_ready(byte_ready)
   );

   usb_host_model i_usb_host_model (
      .clk(clk),
      .req_ready(req_ready),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .byte_last(byte_last),
      .req_valid(req_valid),
      .req_desc(req_desc),
      .req_length(req_length),
      .byte_ready(byte_ready)
   );

   task automatic complete_run();
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   // Hang guard, far above the few thousand cycles the run needs
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         bad_count++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_compared++;
      if (seen !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         bad_count++;
      end
   endtask : chk

   // Expected byte at offset o; store banks mirrored in mem, bank bit 1 is high speed
   function automatic logic [7:0] exp_byte(input logic [1:0] d, input int o);
      logic [79:0] v;
      logic [7:0] iv;
      logic [7:0] attr;
      logic [7:0] pw;
      iv = eeprom_valid ? mem[{high_speed, 5'h00}] : (high_speed ? 8'h04 : 8'h01);
      attr = {1'b1, power_source_strap, remote_wakeup_strap, 5'h00};
      pw = power_source_strap ? 8'h01 : 8'hFA;
      case (d)
         2'h0: v = {8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00, iv, 24'h000000};
         2'h1: v = {8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, attr, pw, 8'h00};
         default: v = {8'h0A, 8'h06, 8'h00, 8'h02, 8'hFF, 8'h00, 8'hFF, 8'h40, 8'h01, 8'h00};
      endcase
      if (eeprom_valid && d == 2'h1)
         return mem[{~high_speed, 5'(o + 1)}];
      if (eeprom_valid && d == 2'h2 && o >= 2 && o <= 8)
         return mem[{~high_speed, 5'(o + 8)}];
      return v[79 - 8 * o -: 8];
   endfunction : exp_byte

   // Mode is {speed, eeprom, power strap, wakeup strap}; straps need two sync cycles
   task automatic run_case(input logic [3:0] m, input logic [1:0] d, input logic [15:0] n,
                           input logic s);
      int dl;
      int cnt;
      @(posedge clk);
      {high_speed, eeprom_valid, power_source_strap, remote_wakeup_strap} <= m;
      repeat (4) @(posedge clk);
      dl = (d == 2'h0) ? 7 : (d == 2'h1) ? 9 : (d == 2'h2) ? 10 : 0;
      cnt = (n < dl) ? n : dl;
      i_usb_host_model.fetch(d, n, cnt, s);
      chk("byte count", 16'(cnt), 16'(i_usb_host_model.got.size()));
      for (int i = 0; i < cnt && i < i_usb_host_model.got.size(); i++)
      begin
         chk("byte data", 16'(exp_byte(d, i)), 16'(i_usb_host_model.got[i]));
         chk("last flag", 16'(i == cnt - 1), 16'(i_usb_host_model.lasts[i]));
      end
   endtask : run_case

   initial
   begin
      logic [7:0] r;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Random store bytes; header fields keep the values the loader must store
      for (int a = 0; a < 64; a++)
      begin
         @(posedge clk);
         r = 8'($random(seed));
         if (a % 32 >= 1 && a % 32 <= 6)
            r = CFG_HDR[55 - 8 * (a % 32) -: 8];
         mem[a] = r;
         load_valid <= 1'b1;
         load_addr <= 6'(a);
         load_data <= r;
      end
      @(posedge clk);
      load_valid <= 1'b0;
      run_case(4'h8, 2'h0, 16'h0040, 1'b1);
      run_case(4'h0, 2'h0, 16'h0007, 1'b0);
      run_case(4'hC, 2'h0, 16'h0007, 1'b0);
      for (int k = 0; k < 4; k++)
         run_case(4'(k), 2'h1, 16'hFFFF, 1'b0);
      run_case(4'h4, 2'h1, 16'h0009, 1'b1);
      run_case(4'hC, 2'h1, 16'h0009, 1'b0);
      run_case(4'h8, 2'h2, 16'h000A, 1'b0);
      run_case(4'h0, 2'h2, 16'hFFFF, 1'b1);
      run_case(4'hC, 2'h2, 16'h000A, 1'b1);
      run_case(4'h4, 2'h2, 16'h000A, 1'b0);
      run_case(4'h8, 2'h2, 16'h0001, 1'b0);
      run_case(4'h8, 2'h1, 16'h0000, 1'b0);
      run_case(4'h0, 2'h3, 16'h0009, 1'b0);
      for (int k = 0; k < 60; k++)
         run_case(4'($random(seed)), 2'($random(seed)), 16'($random(seed) & 15),
                  1'($random(seed)));
      complete_run();
   end
endmodule : tb_usb_descriptor_defaults

// ### bench/usb_descriptor_defaults_sva.sv
`timescale 1ns/1ps

module usb_descriptor_defaults_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [1:0] req_desc,
   input wire logic [15:0] req_length,
   input wire logic req_ready,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_last,
   input wire logic byte_ready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // A request the sequencer must take
   sequence seq_take;
      req_valid && req_ready && req_desc != 2'h3 && req_length != 16'h0000;
   endsequence

   // Address and form cycles, then the byte is offered
   sequence seq_form;
      !byte_valid [*2] ##1 byte_valid;
   endsequence

   a_take_latency: assert property (seq_take |=> seq_form)
      else $error("first byte not offered three cycles after request");
   a_busy_hold: assert property (seq_take |=> !req_ready [*3])
      else $error("request ready during a transfer");
   a_byte_hold: assert property (byte_valid && !byte_ready |=>
      byte_valid && $stable(byte_data) && $stable(byte_last))
      else $error("offered byte changed before acceptance");
   a_next_byte: assert property (byte_valid && byte_ready && !byte_last |=> seq_form)
      else $error("next byte not offered three cycles after acceptance");
   a_last_done: assert property (byte_valid && byte_ready && byte_last |=>
      req_ready && !byte_valid)
      else $error("not idle after final byte");
   a_bad_refused: assert property (req_valid && req_ready &&
      (req_desc == 2'h3 || req_length == 16'h0000) |=> req_ready [*3])
      else $error("illegal or empty request was taken");
   a_qual_header: assert property ((seq_take ##0 req_desc == 2'h2) |->
      ##3 byte_data == 8'h0A)
      else $error("qualifier does not start with its length");
   a_ep_header: assert property ((seq_take ##0 req_desc == 2'h0) |->
      ##3 byte_data == 8'h07)
      else $error("endpoint descriptor does not start with its length");
   a_single_last: assert property ((seq_take ##0 req_length == 16'h0001) |->
      ##3 byte_last)
      else $error("one-byte transfer without last flag");
   a_idle_quiet: assert property (req_ready |-> !byte_valid && !byte_last)
      else $error("byte or last flag offered while idle");
endmodule : usb_descriptor_defaults_sva

bind usb_descriptor_defaults usb_descriptor_defaults_sva i_usb_descriptor_defaults_sva (
   .clk(clk),
   .rst_n(rst_n),
   .req_valid(req_valid),
   .req_desc(req_desc),
   .req_length(req_length),
   .req_ready(req_ready),
   .byte_valid(byte_valid),
   .byte_data(byte_data),
   .byte_last(byte_last),
   .byte_ready(byte_ready)
);

// ### bench/usb_host_model.sv
`timescale 1ns/1ps

// Host side: one descriptor request at a time, bytes drained with optional stalls
module usb_host_model (
   input wire logic clk,
   input wire logic req_ready,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_last,
   output logic req_valid,
   output logic [1:0] req_desc,
   output logic [15:0] req_length,
   output logic byte_ready
);
   logic [7:0] got [$];
   logic lasts [$];
   logic slow = 1'b0;
   int seed = 32'h48c9;

   initial
   begin
      req_valid = 1'b0;
      req_desc = 2'h0;
      req_length = 16'h0000;
   end

   // Collect accepted bytes; random stalls test the hold of an offered byte
   always @(posedge clk)
   begin
      if (byte_valid && byte_ready)
      begin
         got.push_back(byte_data);
         lasts.push_back(byte_last);
      end
      byte_ready <= !slow || ($random(seed) & 1) != 0;
   end

   // Request held until taken, then its fields scrambled so stale values cannot help
   task automatic fetch(input logic [1:0] d, input logic [15:0] n, input int cnt,
                        input logic s);
      int w;
      got.delete();
      lasts.delete();
      slow = s;
      @(posedge clk);
      req_valid <= 1'b1;
      req_desc <= d;
      req_length <= n;
      @(posedge clk);
      while (!req_ready)
         @(posedge clk);
      req_valid <= 1'b0;
      req_desc <= ~d;
      req_length <= ~n;
      w = 0;
      while (got.size() < cnt && w < 300)
      begin
         @(posedge clk);
         w++;
      end
      repeat (6) @(posedge clk);
   endtask : fetch
endmodule : usb_host_model

// ### design/field_store.sv
`timescale 1ns/1ps

// Byte store for EEPROM-loaded descriptor fields; registered read data
module field_store #(
   parameter int ADDR_W = 6
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [7:0] rd_data
);

   logic [7:0] mem [0:(1<<ADDR_W)-1];

   // No reset: contents are only trusted once the loader has filled them
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
   end

endmodule : field_store

// ### design/strap_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for asynchronous strap pins
module strap_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_type;

   sync_state_type st;
   sync_state_type next_st;

   // First stage feeds only the second stage
   always_comb
   begin
      next_st = st;
      for (int i = 0; i < WIDTH; i++)
      begin
         next_st.stage1[i] = pin_in[i];
         next_st.stage2[i] = st.stage1[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign pin_sync = st.stage2;

endmodule : strap_sync

// ### design/usb_descriptor_defaults.sv
// Summary of operation
// RULE1: Interrupt endpoint fixed; only interval from EEPROM.
// RULE2: Separate HS/FS intervals; defaults 04h and 01h.
// RULE3: Other-speed config: length 09h, type 07h, total 0027h.
// RULE4: Other-speed config uses opposite-speed EEPROM values.
// RULE5: Max power default 01h self, FAh bus.
// RULE6: Attributes default A0h shaped by power, wakeup straps.
// RULE7: EEPROM must hold header fields equal defaults.
// RULE8: Defaults: interfaces 01h, value 01h, string 00h.
// RULE9: Qualifier length 0Ah, type 06h, reserved 00h fixed.
// RULE10: Qualifier built from opposite-speed device descriptor.
// RULE11: Qualifier defaults 0200h, FFh, 00h, FFh, 40h, 01h.
// RULE12: Bytes ascending offset, multi-byte fields LSB first.
`timescale 1ns/1ps

module usb_descriptor_defaults
   import usb_descriptor_defaults_pkg::*;
(
   // Clock and synchronous reset
   input wire logic clk,
   input wire logic rst_n,
   // Operating speed, store state and strap pins
   input wire logic high_speed,
   input wire logic eeprom_valid,
   input wire logic power_source_strap,
   input wire logic remote_wakeup_strap,
   // Field store writes from the EEPROM loader
   input wire logic load_valid,
   input wire logic [FIELD_ADDR_W-1:0] load_addr,
   input wire logic [7:0] load_data,
   // Descriptor request from the control endpoint
   input wire logic req_valid,
   input wire logic [1:0] req_desc,
   input wire logic [15:0] req_length,
   output logic req_ready,
   // Descriptor bytes, one per handshake
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic byte_last,
   input wire logic byte_ready
);

   // Whole sequencer state, registered as one word
   typedef struct packed {
      seq_state_type state;
      desc_sel_type desc;
      logic speed_hs;
      logic [3:0] offset;
      logic [3:0] count;
      logic [7:0] data;
      logic last;
   } main_state_type;

   // Present and next state
   main_state_type st;
   main_state_type next_st;

   // Quiet idle state that reset returns to
   localparam main_state_type RESET_ST = '{
      state: ST_IDLE,
      desc: DESC_INTERRUPT_EP,
      speed_hs: BANK_FS,
      offset: OFF_0,
      count: COUNT_NONE,
      data: BYTE_NONE,
      last: 1'h0
   };

   // Synchronised straps, store port and byte forming
   logic [1:0] strap_sync_out;
   logic self_powered;
   logic remote_wakeup;
   logic [FIELD_ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] default_byte;
   logic [7:0] formed_byte;
   logic [3:0] req_full_len;
   logic [3:0] req_count;

   // Straps are pins from outside the clock domain
   strap_sync #(
      .WIDTH(2)
   ) u_strap_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pin_in({remote_wakeup_strap, power_source_strap}),
      .pin_sync(strap_sync_out)
   );

   assign self_powered = strap_sync_out[0];
   assign remote_wakeup = strap_sync_out[1];

   // Loaded fields; read data arrive one cycle after the address
   field_store #(
      .ADDR_W(FIELD_ADDR_W)
   ) u_field_store (
      .clk(clk),
      .wr_en(load_valid),
      .wr_addr(load_addr),
      .wr_data(load_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // Full length of the selected descriptor; unknown codes send nothing
   function automatic logic [3:0] desc_length(input logic [1:0] sel);
      logic [3:0] len;
      len = 4'h0;
      case (sel)
         DESC_INTERRUPT_EP: len = EP_DESC_LEN;
         DESC_OTHER_SPEED_CFG: len = CFG_DESC_LEN;
         DESC_QUALIFIER: len = QUAL_DESC_LEN;
         default: len = 4'h0;
      endcase
      return len;
   endfunction : desc_length

   // Store index holding the EEPROM copy of a descriptor byte
   function automatic logic [FIELD_IDX_W-1:0] field_index(
      input desc_sel_type sel,
      input logic [3:0] off
   );
      logic [FIELD_IDX_W-1:0] idx;
      idx = IDX_EP_INTERVAL;
      unique case (sel)
         DESC_INTERRUPT_EP: idx = IDX_EP_INTERVAL;
         DESC_OTHER_SPEED_CFG: idx = IDX_CFG_LENGTH + FIELD_IDX_W'(off);
         DESC_QUALIFIER: idx = IDX_DEV_BCD_LO + FIELD_IDX_W'(off - OFF_2);
      endcase
      return idx;
   endfunction : field_index

   // Default attributes: nominal A0h with power and wakeup bits from straps
   function automatic logic [7:0] attr_default(input logic self_pwr, input logic wake);
      logic [7:0] attr;
      attr = CFG_ATTR_NOMINAL;
      attr[ATTR_SELF_POWERED_BIT] = self_pwr; // [RULE6]
      attr[ATTR_REMOTE_WAKE_BIT] = wake; // [RULE6]
      return attr;
   endfunction : attr_default

   // Whether a byte has a copy in the store; fixed bytes never come from it
   function automatic logic field_loaded(
      input desc_sel_type sel,
      input logic [3:0] off
   );
      logic loaded;
      loaded = 1'h0;
      unique case (sel)
         DESC_INTERRUPT_EP:
         begin
            // Only the polling interval is loaded
            loaded = (off == OFF_6); // [RULE1]
         end
         DESC_OTHER_SPEED_CFG:
         begin
            // Every header byte is loaded; a bad copy is not repaired
            loaded = 1'h1; // [RULE7] [RULE8]
         end
         DESC_QUALIFIER:
         begin
            // Length, type and reserved byte stay fixed
            loaded = (off >= OFF_2) && (off <= OFF_8); // [RULE9] [RULE11]
         end
      endcase
      return loaded;
   endfunction : field_loaded

   // Full length of the requested descriptor; zero for an unknown code
   assign req_full_len = desc_length(req_desc);

   // Length clipped to the host's requested length
   always_comb
   begin
      if (req_length < 16'(req_full_len))
         req_count = req_length[3:0];
      else
         req_count = req_full_len;
   end

   // Read bank: current speed for the interval, opposite speed otherwise
   always_comb
   begin
      if (st.desc == DESC_INTERRUPT_EP)
         rd_addr = {st.speed_hs ? BANK_HS : BANK_FS, field_index(st.desc, st.offset)}; // [RULE2]
      else
         rd_addr = {st.speed_hs ? BANK_FS : BANK_HS, field_index(st.desc, st.offset)}; // [RULE4] [RULE10]
   end

   // Default byte for the current offset, as sent with no store loaded
   always_comb
   begin
      default_byte = 8'h00;
      unique case (st.desc)
         DESC_INTERRUPT_EP:
         begin
            unique case (st.offset)
               OFF_0: default_byte = {4'h0, EP_DESC_LEN};
               OFF_1: default_byte = EP_TYPE;
               OFF_2: default_byte = EP_ADDRESS; // [RULE1]
               OFF_3: default_byte = EP_ATTR_INTERRUPT; // [RULE1]
               OFF_4: default_byte = EP_MAX_PACKET[7:0]; // [RULE1] [RULE12]
               OFF_5: default_byte = EP_MAX_PACKET[15:8]; // [RULE1] [RULE12]
               default: default_byte = st.speed_hs ? EP_INTERVAL_HS : EP_INTERVAL_FS; // [RULE2]
            endcase
         end
         DESC_OTHER_SPEED_CFG:
         begin
            unique case (st.offset)
               OFF_0: default_byte = {4'h0, CFG_DESC_LEN}; // [RULE3]
               OFF_1: default_byte = CFG_TYPE_OTHER; // [RULE3]
               OFF_2: default_byte = CFG_TOTAL_LEN[7:0]; // [RULE3] [RULE12]
               OFF_3: default_byte = CFG_TOTAL_LEN[15:8]; // [RULE3] [RULE12]
               OFF_4: default_byte = CFG_NUM_IF; // [RULE8]
               OFF_5: default_byte = CFG_VALUE; // [RULE8]
               OFF_6: default_byte = CFG_STRING; // [RULE8]
               OFF_7: default_byte = attr_default(self_powered, remote_wakeup); // [RULE6]
               default: default_byte = self_powered ? CFG_POWER_SELF : CFG_POWER_BUS; // [RULE5]
            endcase
         end
         DESC_QUALIFIER:
         begin
            unique case (st.offset)
               OFF_0: default_byte = {4'h0, QUAL_DESC_LEN}; // [RULE9]
               OFF_1: default_byte = QUAL_TYPE; // [RULE9]
               OFF_2: default_byte = QUAL_BCD_USB[7:0]; // [RULE11] [RULE12]
               OFF_3: default_byte = QUAL_BCD_USB[15:8]; // [RULE11] [RULE12]
               OFF_4: default_byte = QUAL_CLASS; // [RULE11]
               OFF_5: default_byte = QUAL_SUBCLASS; // [RULE11]
               OFF_6: default_byte = QUAL_PROTOCOL; // [RULE11]
               OFF_7: default_byte = QUAL_MAX_PKT0; // [RULE11]
               OFF_8: default_byte = QUAL_NUM_CFG; // [RULE11]
               default: default_byte = QUAL_RESERVED; // [RULE9]
            endcase
         end
      endcase
   end

   // Stored byte wins only where the field has a copy; header bytes are not repaired
   always_comb
   begin
      if (eeprom_valid && field_loaded(st.desc, st.offset))
         formed_byte = rd_data; // [RULE1] [RULE4] [RULE8] [RULE10] [RULE11]
      else
         formed_byte = default_byte;
   end

   // Sequencer: one byte per address/form/send pass
   always_comb
   begin
      next_st = st;
      unique case (st.state)
         ST_IDLE:
         begin
            // Speed is latched per transfer so a mid-transfer change cannot mix banks
            if (req_valid && (req_count != 4'h0))
            begin
               next_st.desc = desc_sel_type'(req_desc);
               next_st.speed_hs = high_speed;
               next_st.offset = OFF_0;
               next_st.count = req_count;
               next_st.state = ST_ADDR;
            end
         end
         ST_ADDR:
         begin
            next_st.state = ST_FORM;
         end
         ST_FORM:
         begin
            next_st.data = formed_byte;
            next_st.last = (st.count == 4'h1);
            next_st.state = ST_SEND;
         end
         ST_SEND:
         begin
            if (byte_ready)
            begin
               // Ascending offsets, stop at the clipped count
               next_st.offset = st.offset + 4'h1; // [RULE12]
               next_st.count = st.count - 4'h1;
               if (st.last)
               begin
                  // Last flag drops with the return to idle
                  next_st.state = ST_IDLE;
                  next_st.last = 1'h0;
               end
               else
                  next_st.state = ST_ADDR;
            end
         end
      endcase
   end

   // Synchronous reset to the quiet idle state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st <= RESET_ST;
      else
         st <= next_st;
   end

   // Handshake outputs decoded from state; data from flops
   assign req_ready = (st.state == ST_IDLE);
   assign byte_valid = (st.state == ST_SEND);
   assign byte_data = st.data;
   assign byte_last = st.last;

endmodule : usb_descriptor_defaults

// ### design/usb_descriptor_defaults_pkg.sv
package usb_descriptor_defaults_pkg;

   // Descriptor selector carried with a request
   typedef enum logic [1:0] {
      DESC_INTERRUPT_EP = 2'h0,
      DESC_OTHER_SPEED_CFG = 2'h1,
      DESC_QUALIFIER = 2'h2
   } desc_sel_type;

   // Sequencer states, Gray coded along idle -> address -> form -> send
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ADDR = 2'h1,
      ST_FORM = 2'h3,
      ST_SEND = 2'h2
   } seq_state_type;

   // Field store geometry: one bank per speed, bank 1 holds high-speed values
   localparam int FIELD_ADDR_W = 6;
   localparam int FIELD_IDX_W = 5;
   localparam logic BANK_FS = 1'h0;
   localparam logic BANK_HS = 1'h1;

   // Field indices within a speed bank, as written by the EEPROM loader
   localparam logic [4:0] IDX_EP_INTERVAL = 5'h00;
   localparam logic [4:0] IDX_CFG_LENGTH = 5'h01;
   localparam logic [4:0] IDX_CFG_TYPE = 5'h02;
   localparam logic [4:0] IDX_CFG_TOTAL_LO = 5'h03;
   localparam logic [4:0] IDX_CFG_TOTAL_HI = 5'h04;
   localparam logic [4:0] IDX_CFG_NUM_IF = 5'h05;
   localparam logic [4:0] IDX_CFG_VALUE = 5'h06;
   localparam logic [4:0] IDX_CFG_STRING = 5'h07;
   localparam logic [4:0] IDX_CFG_ATTR = 5'h08;
   localparam logic [4:0] IDX_CFG_MAX_POWER = 5'h09;
   localparam logic [4:0] IDX_DEV_BCD_LO = 5'h0A;
   localparam logic [4:0] IDX_DEV_BCD_HI = 5'h0B;
   localparam logic [4:0] IDX_DEV_CLASS = 5'h0C;
   localparam logic [4:0] IDX_DEV_SUBCLASS = 5'h0D;
   localparam logic [4:0] IDX_DEV_PROTOCOL = 5'h0E;
   localparam logic [4:0] IDX_DEV_MAX_PKT0 = 5'h0F;
   localparam logic [4:0] IDX_DEV_NUM_CFG = 5'h10;

   // Descriptor lengths in bytes
   localparam logic [3:0] EP_DESC_LEN = 4'h7;
   localparam logic [3:0] CFG_DESC_LEN = 4'h9;
   localparam logic [3:0] QUAL_DESC_LEN = 4'hA;

   // Byte offsets inside the descriptors
   localparam logic [3:0] OFF_0 = 4'h0;
   localparam logic [3:0] OFF_1 = 4'h1;
   localparam logic [3:0] OFF_2 = 4'h2;
   localparam logic [3:0] OFF_3 = 4'h3;
   localparam logic [3:0] OFF_4 = 4'h4;
   localparam logic [3:0] OFF_5 = 4'h5;
   localparam logic [3:0] OFF_6 = 4'h6;
   localparam logic [3:0] OFF_7 = 4'h7;
   localparam logic [3:0] OFF_8 = 4'h8;

   // Reset values of the sequencer's byte count and data register
   localparam logic [3:0] COUNT_NONE = 4'h0;
   localparam logic [7:0] BYTE_NONE = 8'h00;

   // Interrupt endpoint descriptor values
   localparam logic [7:0] EP_TYPE = 8'h05;
   localparam logic [7:0] EP_ADDRESS = 8'h83;
   localparam logic [7:0] EP_ATTR_INTERRUPT = 8'h03;
   localparam logic [15:0] EP_MAX_PACKET = 16'h0010;
   localparam logic [7:0] EP_INTERVAL_HS = 8'h04;
   localparam logic [7:0] EP_INTERVAL_FS = 8'h01;

   // Other-speed configuration defaults
   localparam logic [7:0] CFG_TYPE_OTHER = 8'h07;
   localparam logic [15:0] CFG_TOTAL_LEN = 16'h0027;
   localparam logic [7:0] CFG_NUM_IF = 8'h01;
   localparam logic [7:0] CFG_VALUE = 8'h01;
   localparam logic [7:0] CFG_STRING = 8'h00;
   localparam logic [7:0] CFG_ATTR_NOMINAL = 8'hA0;
   localparam int ATTR_SELF_POWERED_BIT = 6;
   localparam int ATTR_REMOTE_WAKE_BIT = 5;
   localparam logic [7:0] CFG_POWER_SELF = 8'h01;
   localparam logic [7:0] CFG_POWER_BUS = 8'hFA;

   // Device qualifier defaults
   localparam logic [7:0] QUAL_TYPE = 8'h06;
   localparam logic [15:0] QUAL_BCD_USB = 16'h0200;
   localparam logic [7:0] QUAL_CLASS = 8'hFF;
   localparam logic [7:0] QUAL_SUBCLASS = 8'h00;
   localparam logic [7:0] QUAL_PROTOCOL = 8'hFF;
   localparam logic [7:0] QUAL_MAX_PKT0 = 8'h40;
   localparam logic [7:0] QUAL_NUM_CFG = 8'h01;
   localparam logic [7:0] QUAL_RESERVED = 8'h00;

endpackage : usb_descriptor_defaults_pkg
